/* amp_ctrl_pkg.sv */
/*
  Package for the amplifier system control register bank: offsets, field
  positions, reset values, decoded setting types.
  Assumes an 8-bit register port with one-cycle strobes.
*/
package amp_ctrl_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFS_ERR_FLAGS = 8'h02;
  localparam logic [7:0] OFS_SYS_CTRL_ONE = 8'h03;
  localparam logic [7:0] OFS_SERIAL_FMT = 8'h04;
  localparam logic [7:0] OFS_SYS_CTRL_TWO = 8'h05;
  localparam logic [7:0] OFS_SHUTDOWN_GROUP = 8'h19;
  localparam logic [7:0] OFS_CLOCK_STATUS = 8'h40;

  // ==========================================================================
  // Error flag bit positions
  localparam int ERR_MCLK_BIT = 7;
  localparam int ERR_PLL_BIT = 6;
  localparam int ERR_BCLK_BIT = 5;
  localparam int ERR_WSCLK_BIT = 4;
  localparam int ERR_SLIP_BIT = 3;
  localparam logic [7:0] ERR_USED_MASK = 8'hf8;

  // ==========================================================================
  // System control one fields
  localparam int SC1_DCBLOCK_BIT = 7;
  localparam int SC1_HARDUNMUTE_BIT = 5;
  localparam int SC1_AUTODIS_BIT = 3;
  localparam int SC1_SOFTDIS_BIT = 2;
  localparam logic [7:0] SC1_WRITE_MASK = 8'haf;
  localparam logic [7:0] SC1_RESET = 8'ha0;

  // ==========================================================================
  // Serial format and system control two fields
  localparam logic [7:0] FMT_WRITE_MASK = 8'h1f;
  localparam logic [7:0] FMT_RESET = 8'h05;
  localparam int SC2_SHUTDOWN_BIT = 6;
  localparam int SC2_ALLCH_BIT = 5;
  localparam int SC2_CHVOL_BIT = 3;
  localparam int SC2_LINEOUT_BIT = 2;
  localparam int SC2_HPFORCE_BIT = 1;
  localparam logic [7:0] SC2_WRITE_MASK = 8'h6e;
  localparam logic [7:0] SC2_RESET = 8'h40;
  localparam logic [7:0] SDG_RESET = 8'h00;
  localparam int NUM_CHANNELS = 6;

  // ==========================================================================
  // Decoded setting types
  typedef enum logic [1:0] {
    DEEMPH_NONE = 2'b00,
    DEEMPH_RSVD = 2'b01,
    DEEMPH_44K1 = 2'b10,
    DEEMPH_48K = 2'b11
  } deemph_e;

  typedef enum logic [1:0] {
    FRAME_RIGHT = 2'b00,
    FRAME_STANDARD = 2'b01,
    FRAME_LEFT = 2'b10,
    FRAME_INVALID = 2'b11
  } frame_e;

  typedef enum logic [1:0] {
    OUT_SPEAKER = 2'b00,
    OUT_HEADPHONE = 2'b01,
    OUT_LINE = 2'b10
  } outmode_e;

  typedef struct packed {
    frame_e frame;
    logic [4:0] wordBits;
    logic bclk32;
  } serial_fmt_s;

  typedef struct packed {
    logic mclk;
    logic pll;
    logic bclk;
    logic wsclk;
    logic slip;
  } clk_err_s;

endpackage

/* sticky_flags.sv */
/*
  Sticky error flag set: hardware sets, host write of zero clears.
  Assumes event pulses come from the same clock domain.
*/
`timescale 1ns/1ps
module sticky_flags
  import amp_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Events and host clear
  input wire logic [4:0] eventIn,
  input wire logic clearWrite,
  input wire logic [4:0] clearData,
  // Flags
  output logic [4:0] flagsQ
);

  // ==========================================================================
  // One sticky flag per error source; a set in the clear cycle wins
  genvar i;
  generate
    for (i = 0; i < 5; i++) begin : gFlag
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          flagsQ[i] <= 1'b0;
        end else if (eventIn[i]) begin
          flagsQ[i] <= 1'b1; // RULE1
        end else if (clearWrite && !clearData[i]) begin
          flagsQ[i] <= 1'b0; // RULE1
        end
      end
    end
  endgenerate

endmodule

/* format_decode.sv */
/*
  Decoder of the five-bit serial input format code.
  Pure combinational; reserved codes mark the frame invalid.
*/
`timescale 1ns/1ps
module format_decode
  import amp_ctrl_pkg::*;
(
  // Code in
  input wire logic [4:0] code,
  // Decoded format
  output serial_fmt_s fmt
);

  // ==========================================================================
  // Map each documented code to framing, word length and bit clock variant
  always_comb begin
    fmt = '{frame: FRAME_INVALID, wordBits: 5'h00, bclk32: 1'b0};
    case (code) // RULE11
      5'h00: fmt = '{frame: FRAME_RIGHT, wordBits: 5'h10, bclk32: 1'b0};
      5'h01: fmt = '{frame: FRAME_RIGHT, wordBits: 5'h14, bclk32: 1'b0};
      5'h02: fmt = '{frame: FRAME_RIGHT, wordBits: 5'h18, bclk32: 1'b0};
      5'h03: fmt = '{frame: FRAME_STANDARD, wordBits: 5'h10, bclk32: 1'b0};
      5'h04: fmt = '{frame: FRAME_STANDARD, wordBits: 5'h14, bclk32: 1'b0};
      5'h05: fmt = '{frame: FRAME_STANDARD, wordBits: 5'h18, bclk32: 1'b0};
      5'h06: fmt = '{frame: FRAME_LEFT, wordBits: 5'h10, bclk32: 1'b0};
      5'h07: fmt = '{frame: FRAME_LEFT, wordBits: 5'h14, bclk32: 1'b0};
      5'h08: fmt = '{frame: FRAME_LEFT, wordBits: 5'h18, bclk32: 1'b0};
      5'h0a: fmt = '{frame: FRAME_RIGHT, wordBits: 5'h12, bclk32: 1'b0};
      5'h13: fmt = '{frame: FRAME_STANDARD, wordBits: 5'h10, bclk32: 1'b1};
      5'h16: fmt = '{frame: FRAME_LEFT, wordBits: 5'h10, bclk32: 1'b1};
      default: fmt = '{frame: FRAME_INVALID, wordBits: 5'h00, bclk32: 1'b0};
    endcase
  end

endmodule

/* audio_amp_system_control_regs.sv */
/*
  Control and status register bank of a digital audio amplifier: sticky
  clock error flags, system control one and two, serial input format,
  shutdown group, and the derived control outputs for the audio processor.
  Assumes error event pulses and detected clock values on sys_clk; the
  headphone select pin is asynchronous and is synchronised here.
*/
// Implementation choice: the strobed register port.
`timescale 1ns/1ps

// What this block does
// RULE1: Error flags are sticky; only a host write of zero clears them.
// RULE2: Host clears the error register, then reads back to see persistent errors.
// RULE3: Error register bits 6..3: lock, bit clock, word clock, frame slip.
// RULE4: Bit 7 of the error register reports a sticky master clock error.
// RULE5: Control one bit 7 enables dc-blocking filter, default on.
// RULE6: Control one bit 5 picks hard (1, default) or soft unmute after errors.
// RULE7: Control one bit 3 low enables clock autodetect, high uses manual clocks.
// RULE8: With autodetect active, detected clock values show in the clock status.
// RULE9: Control one bit 2 low enables soft start, high skips it.
// RULE10: De-emphasis field: 00 none, 01 reserved, 10 44.1 kHz, 11 48 kHz.
// RULE11: Format register keeps bits 7..5 zero and decodes a five-bit code.
// RULE12: Format resets to 24-bit standard framing, code 00101.
// RULE13: Control two bit 6 high shuts all outputs with hard mute; headphonePwmActive still follows the output mode.
// RULE14: Bit 5 set runs all channels; clear runs only non-shutdown-group channels.
// RULE15: Host changes bit 5 only while bit 6 is set.
// RULE16: Valid flag is 0 in shutdown, 1 when all channels run.
// RULE17: Control two bit 3 chooses headphone or channel volume registers.
// RULE18: Mode 00 is speaker, headphone when the select pin is high.
// RULE19: Bit 1 forces headphone mode and mutes non-headphone channels.
// RULE20: Headphone request by register is ORed with the select pin.
// RULE21: Bit 2 selects line-out: all outputs active, select pin ignored.
// RULE22: Host sets bit 3 together with line-out mode.
// RULE23: Host writes zero to reserved bits and avoids reserved codes.
module audio_amp_system_control_regs
  import amp_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // Error events from the clock monitor
  input wire clk_err_s clkErrEvent,
  // Detected clock values from the autodetector
  input wire logic [5:0] detectedClock,
  // External headphone select pin
  input wire logic headphoneSelectPin,
  // Controls to the audio processor
  output logic dcBlockEnable,
  output logic hardUnmute,
  output logic autoDetectEnable,
  output logic softStartEnable,
  output deemph_e deemphMode,
  output serial_fmt_s serialFormat,
  output logic [NUM_CHANNELS-1:0] channelRun,
  output logic outputsValidFlag,
  output logic useChannelVolume,
  output outmode_e outputMode,
  output logic headphonePwmActive,
  output logic speakerMute
);

  // ==========================================================================
  // Storage
  logic [7:0] sysCtrlOne_q;
  logic [7:0] serialFmt_q;
  logic [7:0] sysCtrlTwo_q;
  logic [7:0] shutdownGroup_q;
  logic [5:0] clockStatus_q;
  logic [4:0] errFlags;
  logic [7:0] errByte;
  logic hpSync1_q;
  logic hpSync2_q;
  logic headphoneReq;
  serial_fmt_s fmtDecoded;
  outmode_e modeSel;
  logic [NUM_CHANNELS-1:0] runSel;
  logic errWrite;

  // ==========================================================================
  // Write decode
  assign errWrite = regWrite && (regAddr == OFS_ERR_FLAGS);

  // ==========================================================================
  // Sticky error flags
  sticky_flags uFlags (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .eventIn({clkErrEvent.mclk, clkErrEvent.pll, clkErrEvent.bclk,
              clkErrEvent.wsclk, clkErrEvent.slip}),
    .clearWrite(errWrite),
    .clearData(regWrData[ERR_MCLK_BIT:ERR_SLIP_BIT]),
    .flagsQ(errFlags)
  );

  // Error flags placed at their register bits, the rest zero
  assign errByte = {errFlags, 3'b000}; // RULE3 RULE4

  // ==========================================================================
  // Format decoder
  format_decode uFmt (
    .code(serialFmt_q[4:0]),
    .fmt(fmtDecoded)
  );

  // ==========================================================================
  // System control one
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sysCtrlOne_q <= SC1_RESET;
    end else if (regWrite && regAddr == OFS_SYS_CTRL_ONE) begin
      sysCtrlOne_q <= regWrData & SC1_WRITE_MASK;
    end
  end

  // ==========================================================================
  // Serial input format; upper bits forced to zero
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      serialFmt_q <= FMT_RESET; // RULE12
    end else if (regWrite && regAddr == OFS_SERIAL_FMT) begin
      serialFmt_q <= regWrData & FMT_WRITE_MASK; // RULE11
    end
  end

  // ==========================================================================
  // System control two; starts shut down
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sysCtrlTwo_q <= SC2_RESET;
    end else if (regWrite && regAddr == OFS_SYS_CTRL_TWO) begin
      sysCtrlTwo_q <= regWrData & SC2_WRITE_MASK;
    end
  end

  // ==========================================================================
  // Shutdown group membership, one bit per channel
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      shutdownGroup_q <= SDG_RESET;
    end else if (regWrite && regAddr == OFS_SHUTDOWN_GROUP) begin
      shutdownGroup_q <= {2'b00, regWrData[NUM_CHANNELS-1:0]};
    end
  end

  // ==========================================================================
  // Clock status follows the detector only while autodetect is on
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      clockStatus_q <= 6'h00;
    end else if (!sysCtrlOne_q[SC1_AUTODIS_BIT]) begin
      clockStatus_q <= detectedClock; // RULE8
    end
  end

  // ==========================================================================
  // Headphone select pin synchroniser
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hpSync1_q <= 1'b0;
      hpSync2_q <= 1'b0;
    end else begin
      hpSync1_q <= headphoneSelectPin;
      hpSync2_q <= hpSync1_q;
    end
  end

  // ==========================================================================
  // Output mode and channel run selection
  always_comb begin
    headphoneReq = sysCtrlTwo_q[SC2_HPFORCE_BIT] | hpSync2_q; // RULE20
    modeSel = OUT_SPEAKER;
    case ({sysCtrlTwo_q[SC2_LINEOUT_BIT], sysCtrlTwo_q[SC2_HPFORCE_BIT]})
      2'b00: modeSel = headphoneReq ? OUT_HEADPHONE : OUT_SPEAKER; // RULE18
      2'b01: modeSel = OUT_HEADPHONE; // RULE19
      2'b10: modeSel = OUT_LINE; // RULE21
      default: modeSel = OUT_SPEAKER;
    endcase
    if (sysCtrlTwo_q[SC2_SHUTDOWN_BIT]) begin
      runSel = '0; // RULE13
    end else if (sysCtrlTwo_q[SC2_ALLCH_BIT]) begin
      runSel = '1; // RULE14
    end else begin
      runSel = ~shutdownGroup_q[NUM_CHANNELS-1:0]; // RULE14
    end
  end

  // ==========================================================================
  // Registered control outputs
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dcBlockEnable <= 1'b1;
      hardUnmute <= 1'b1;
      autoDetectEnable <= 1'b1;
      softStartEnable <= 1'b1;
      deemphMode <= DEEMPH_NONE;
      serialFormat <= '{frame: FRAME_STANDARD, wordBits: 5'h18, bclk32: 1'b0};
    end else begin
      dcBlockEnable <= sysCtrlOne_q[SC1_DCBLOCK_BIT]; // RULE5
      hardUnmute <= sysCtrlOne_q[SC1_HARDUNMUTE_BIT]; // RULE6
      autoDetectEnable <= !sysCtrlOne_q[SC1_AUTODIS_BIT]; // RULE7
      softStartEnable <= !sysCtrlOne_q[SC1_SOFTDIS_BIT]; // RULE9
      deemphMode <= deemph_e'(sysCtrlOne_q[1:0]); // RULE10
      serialFormat <= fmtDecoded; // RULE11
    end
  end

  // ==========================================================================
  // Registered play, mode and volume outputs
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      channelRun <= '0;
      outputsValidFlag <= 1'b0;
      useChannelVolume <= 1'b0;
      outputMode <= OUT_SPEAKER;
      headphonePwmActive <= 1'b0;
      speakerMute <= 1'b1;
    end else begin
      channelRun <= runSel;
      outputsValidFlag <= &runSel; // RULE16
      useChannelVolume <= sysCtrlTwo_q[SC2_CHVOL_BIT]; // RULE17
      outputMode <= modeSel;
      headphonePwmActive <= (modeSel != OUT_SPEAKER);
      speakerMute <= sysCtrlTwo_q[SC2_SHUTDOWN_BIT] || (modeSel == OUT_HEADPHONE); // RULE19
    end
  end

  // ==========================================================================
  // Read data, valid the cycle after the read strobe; unmapped reads zero
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        OFS_ERR_FLAGS: regRdData <= errByte & ERR_USED_MASK;
        OFS_SYS_CTRL_ONE: regRdData <= sysCtrlOne_q;
        OFS_SERIAL_FMT: regRdData <= serialFmt_q;
        OFS_SYS_CTRL_TWO: regRdData <= sysCtrlTwo_q;
        OFS_SHUTDOWN_GROUP: regRdData <= shutdownGroup_q;
        OFS_CLOCK_STATUS: regRdData <= {clockStatus_q, 2'b00};
        default: regRdData <= 8'h00;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end

endmodule

/* amp_ctrl_sva.sv */
/*
  Checker for the amplifier control register bank: error flag reads, control
  outputs following writes, run and mode relations.
  Assumes it is bound to the bank's top module and sees only its ports.
*/
`timescale 1ns/1ps
module amp_ctrl_sva
  import amp_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  // Events and controls
  input wire clk_err_s clkErrEvent,
  input wire logic dcBlockEnable,
  input wire logic autoDetectEnable,
  input wire deemph_e deemphMode,
  input wire serial_fmt_s serialFormat,
  input wire logic [NUM_CHANNELS-1:0] channelRun,
  input wire logic outputsValidFlag,
  input wire outmode_e outputMode,
  input wire logic headphonePwmActive,
  input wire logic speakerMute
);
  // ==========================================================================
  // Write decodes
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire logic [4:0] errEvt = clkErrEvent;
  wire logic wrOne = regWrite && regAddr == OFS_SYS_CTRL_ONE;
  wire logic wrTwo = regWrite && regAddr == OFS_SYS_CTRL_TWO;

  // ==========================================================================
  // Properties
  property p_err_read;
    regRead && regAddr == OFS_ERR_FLAGS |=> regRdData[2:0] == 3'h0 && (regRdData[7:3] & $past(errEvt, 2)) == $past(errEvt, 2);
  endproperty
  a_err_read: assert property (p_err_read) else $error("error flag missing on read");
  property p_dc;
    wrOne |-> ##2 dcBlockEnable == $past(regWrData[SC1_DCBLOCK_BIT], 2);
  endproperty
  a_dc: assert property (p_dc) else $error("dc blocking enable wrong");
  property p_auto;
    wrOne |-> ##2 autoDetectEnable == !$past(regWrData[SC1_AUTODIS_BIT], 2);
  endproperty
  a_auto: assert property (p_auto) else $error("autodetect enable wrong");
  property p_deemph;
    wrOne |-> ##2 deemphMode == deemph_e'($past(regWrData[1:0], 2));
  endproperty
  a_deemph: assert property (p_deemph) else $error("de-emphasis mode wrong");
  property p_fmt_reset;
    $rose(rstn) |-> serialFormat == {FRAME_STANDARD, 5'd24, 1'b0};
  endproperty
  a_fmt_reset: assert property (p_fmt_reset) else $error("format not default after reset");
  property p_shut;
    wrTwo && regWrData[SC2_SHUTDOWN_BIT] |-> ##2 channelRun == '0 && !outputsValidFlag && speakerMute;
  endproperty
  a_shut: assert property (p_shut) else $error("outputs not shut down");
  property p_allrun;
    wrTwo && regWrData[6:5] == 2'b01 |-> ##2 &channelRun && outputsValidFlag;
  endproperty
  a_allrun: assert property (p_allrun) else $error("not all channels running");
  property p_hp;
    outputMode == OUT_HEADPHONE |-> speakerMute && headphonePwmActive;
  endproperty
  a_hp: assert property (p_hp) else $error("headphone mode outputs wrong");
  property p_line;
    outputMode == OUT_LINE |-> headphonePwmActive;
  endproperty
  a_line: assert property (p_line) else $error("line mode headphone outputs off");
endmodule

bind audio_amp_system_control_regs amp_ctrl_sva chk (.sys_clk, .rstn, .regAddr, .regWrData, .regWrite, .regRead,
  .regRdData, .clkErrEvent, .dcBlockEnable, .autoDetectEnable, .deemphMode, .serialFormat, .channelRun,
  .outputsValidFlag, .outputMode, .headphonePwmActive, .speakerMute);

/* amp_host.sv */
/*
  Host model: byte writes and reads on the register port.
  Assumes the bench calls its tasks from one process.
*/
`timescale 1ns/1ps
module amp_host
  import amp_ctrl_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Register port
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrite,
  output logic regRead,
  input wire logic [7:0] regRdData
);
  // ==========================================================================
  // Bus idle at time zero
  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
  end
  // One write; released lines show inverted values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask
  // One read; data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    #1 d = regRdData;
  endtask
  // Control two update: shut down with the old configuration first, then move it
  task automatic sc2(input logic [7:0] d);
    logic [7:0] v;
    logic [7:0] old;
    v = (d | {4'h0, d[SC2_LINEOUT_BIT], 3'h0}) & SC2_WRITE_MASK;
    rd(OFS_SYS_CTRL_TWO, old);
    wr(OFS_SYS_CTRL_TWO, old | 8'h40);
    wr(OFS_SYS_CTRL_TWO, v | 8'h40);
    wr(OFS_SYS_CTRL_TWO, v);
  endtask
  // Clear the error flags, then read back the persistent ones
  task automatic errCheck(output logic [7:0] d);
    wr(OFS_ERR_FLAGS, 8'h00);
    rd(OFS_ERR_FLAGS, d);
  endtask
endmodule

/* testbench.sv */
/*
  Self-checking bench of the amplifier control register bank.
  Assumes the host model drives the register port.
*/
`timescale 1ns/1ps
module testbench
  import amp_ctrl_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  clk_err_s clkErrEvent = '0;
  logic [5:0] detectedClock = 6'h2b;
  logic headphoneSelectPin = 1'b0;
  wire logic [7:0] regAddr, regWrData, regRdData;
  wire logic regWrite, regRead;
  logic dcBlockEnable, hardUnmute, autoDetectEnable, softStartEnable, outputsValidFlag, useChannelVolume;
  logic headphonePwmActive, speakerMute;
  deemph_e deemphMode;
  serial_fmt_s serialFormat;
  logic [5:0] channelRun;
  outmode_e outputMode;
  int miscompares = 0, checks_done = 0, cycles = 0, i;
  logic [7:0] d;
  // Case tables: address, written, read back / code, decoded / control one, outputs / pin, control two, modes
  logic [23:0] regRows [9] = '{{OFS_SYS_CTRL_ONE, 8'hff, 8'haf}, {OFS_SYS_CTRL_ONE, 8'h02, 8'h02},
    {OFS_SERIAL_FMT, 8'hff, 8'h1f}, {OFS_SERIAL_FMT, 8'h13, 8'h13}, {OFS_SYS_CTRL_TWO, 8'h48, 8'h48},
    {OFS_SYS_CTRL_TWO, 8'h68, 8'h68}, {OFS_SHUTDOWN_GROUP, 8'hff, 8'h3f}, {OFS_CLOCK_STATUS, 8'h00, 8'hac},
    {8'h77, 8'h5a, 8'h00}};
  logic [12:0] fmtRows [9] = '{{5'h00, FRAME_RIGHT, 5'd16, 1'b0}, {5'h01, FRAME_RIGHT, 5'd20, 1'b0},
    {5'h02, FRAME_RIGHT, 5'd24, 1'b0}, {5'h03, FRAME_STANDARD, 5'd16, 1'b0}, {5'h04, FRAME_STANDARD, 5'd20, 1'b0},
    {5'h06, FRAME_LEFT, 5'd16, 1'b0}, {5'h08, FRAME_LEFT, 5'd24, 1'b0}, {5'h0a, FRAME_RIGHT, 5'd18, 1'b0},
    {5'h13, FRAME_STANDARD, 5'd16, 1'b1}};
  logic [15:0] sc1Rows [3] = '{16'h0003, 16'ha00f, 16'h2c04};
  logic [16:0] modeRows [5] = '{{1'b1, 8'h20, 8'h61}, {1'b0, 8'h20, 8'h00}, {1'b0, 8'h22, 8'h61},
    {1'b1, 8'h24, 8'hc2}, {1'b0, 8'h28, 8'h80}};
  logic [15:0] resRows [5] = '{16'h0200, 16'h03a0, 16'h0405, 16'h0540, 16'h1900};

  // ==========================================================================
  // Clock, models and timeout
  always #5 sys_clk = ~sys_clk;
  audio_amp_system_control_regs dut (.sys_clk, .rstn, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
    .clkErrEvent, .detectedClock, .headphoneSelectPin, .dcBlockEnable, .hardUnmute, .autoDetectEnable,
    .softStartEnable, .deemphMode, .serialFormat, .channelRun, .outputsValidFlag, .useChannelVolume, .outputMode,
    .headphonePwmActive, .speakerMute);
  amp_host host (.sys_clk, .regAddr, .regWrData, .regWrite, .regRead, .regRdData);
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      test_done;
    end
  end

  // ==========================================================================
  // Compare, settle and verdict
  task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task automatic settle;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task automatic test_done;
    $display("Checks made: %0d, miscompares: %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    for (i = 0; i < 9; i++) begin
      host.wr(regRows[i][23:16], regRows[i][15:8]);
      host.rd(regRows[i][23:16], d);
      cmp8("register readback", regRows[i][7:0], d);
    end
    for (i = 0; i < 9; i++) begin
      host.wr(OFS_SERIAL_FMT, {3'h0, fmtRows[i][12:8]});
      settle;
      cmp8("serial format", fmtRows[i][7:0], serialFormat);
    end
    host.wr(OFS_SERIAL_FMT, 8'h09);
    settle;
    cmp8("reserved frame", {6'h0, FRAME_INVALID}, {6'h0, serialFormat.frame});
    for (i = 0; i < 4; i++) begin
      host.wr(OFS_SYS_CTRL_ONE, 8'(i));
      settle;
      cmp8("de-emphasis", 8'(i), {6'h0, deemphMode});
    end
    for (i = 0; i < 3; i++) begin
      host.wr(OFS_SYS_CTRL_ONE, sc1Rows[i][15:8]);
      settle;
      cmp8("control one outputs", sc1Rows[i][7:0], {4'h0, dcBlockEnable, hardUnmute, autoDetectEnable,
        softStartEnable});
    end
    // Sticky flags: set, hold, partial clear, full clear, persistent error
    @(posedge sys_clk) clkErrEvent <= 5'h1f;
    @(posedge sys_clk) clkErrEvent <= 5'h00;
    host.rd(OFS_ERR_FLAGS, d);
    cmp8("error flags", 8'hf8, d);
    repeat (5) @(posedge sys_clk);
    host.rd(OFS_ERR_FLAGS, d);
    cmp8("error flags held", 8'hf8, d);
    host.wr(OFS_ERR_FLAGS, 8'hf0);
    host.rd(OFS_ERR_FLAGS, d);
    cmp8("error flags partial clear", 8'hf0, d);
    host.errCheck(d);
    cmp8("error flags cleared", 8'h00, d);
    @(posedge sys_clk) clkErrEvent <= 5'h08;
    host.errCheck(d);
    cmp8("persistent lock error", 8'h40, d);
    @(posedge sys_clk) clkErrEvent <= 5'h00;
    // Channel runs against the shutdown group
    host.wr(OFS_SHUTDOWN_GROUP, 8'h05);
    host.sc2(8'h00);
    settle;
    cmp8("run subset", 8'h3a, {1'b0, outputsValidFlag, channelRun});
    host.sc2(8'h20);
    settle;
    cmp8("run all", 8'h7f, {1'b0, outputsValidFlag, channelRun});
    host.sc2(8'h60);
    settle;
    cmp8("shutdown", 8'h80, {speakerMute, outputsValidFlag, channelRun});
    // Output modes against the headphone pin
    for (i = 0; i < 5; i++) begin
      @(posedge sys_clk) headphoneSelectPin <= modeRows[i][16];
      host.sc2(modeRows[i][15:8]);
      settle;
      cmp8("output mode", modeRows[i][7:0], {useChannelVolume, headphonePwmActive, speakerMute, 3'h0,
        outputMode});
    end
    // Clock status tracks detection only while autodetect is on
    @(posedge sys_clk) detectedClock <= 6'h15;
    host.wr(OFS_SYS_CTRL_ONE, 8'h00);
    settle;
    host.rd(OFS_CLOCK_STATUS, d);
    cmp8("clock status", 8'h54, d);
    host.wr(OFS_SYS_CTRL_ONE, 8'h08);
    settle;
    @(posedge sys_clk) detectedClock <= 6'h3f;
    settle;
    host.rd(OFS_CLOCK_STATUS, d);
    cmp8("clock status frozen", 8'h54, d);
    // Second reset in mid-run, then reset values
    @(posedge sys_clk) rstn <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    for (i = 0; i < 5; i++) begin
      host.rd(resRows[i][15:8], d);
      cmp8("reset value", resRows[i][7:0], d);
    end
    cmp8("reset control one", 8'h0f, {4'h0, dcBlockEnable, hardUnmute, autoDetectEnable,
      softStartEnable});
    cmp8("reset format", {FRAME_STANDARD, 5'd24, 1'b0}, serialFormat);
    test_done;
  end
endmodule
